// File: design/clock_and_reset_control.sv
// Clock enables, halt control, reset sequencing and slow clock routing.
// Assumes the serial bus front end reports start conditions and decoded commands
// as single-cycle pulses on this clock; slow clock pins arrive asynchronously.
`timescale 1ns/1ps
module clock_and_reset_control #(
    parameter int unsigned irq_set_cycles = clock_reset_pkg::irq_set_cycles,
    parameter int unsigned irq_clear_cycles = clock_reset_pkg::irq_clear_cycles,
    parameter int unsigned idle_width = 24
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic reset_pin_n, // External reset pin, active low, async
    input wire logic por_active, // Supply below power_on_threshold, async
    input wire logic por_rc_tick, // On-chip RC clock tick, same domain
    input wire logic reset_command, // Reset command pulse from host
    input wire logic cfg_write, // Clock configuration write pulse
    input wire logic [7:0] cfg_data, // Written configuration byte
    input wire logic init_command, // Host configuration command pulse
    input wire logic push_pull_set, // Host selects push-pull interrupt
    input wire logic [idle_width-1:0] idle_limit, // Inactivity before halt
    input wire logic activity, // Any processing activity
    input wire logic key_event, // Key press or release pulse
    input wire logic bus_start, // Bus start condition pulse
    input wire logic slow_clock_input, // External slow clock pin, async
    input wire logic crystal_input, // Crystal oscillator output, async
    input wire logic [1:0] addr_pins, // Address-select pins, async
    input wire logic scan_out_8, // Keypad scan output 8 value
    input wire logic scan_out_8_oe_n, // Keypad scan output 8 enable, low drives
    output logic [7:0] clock_configuration, // Read-back of configuration
    output logic proc_tick, // Processing clock enable pulse
    output logic pwm_tick, // PWM timebase pulse
    output logic pwm_timebase, // Selected PWM timebase level
    output logic halted, // Processing clock stopped
    output logic in_reset, // Internal reset active
    output logic [6:0] bus_address, // Selected bus address
    output logic addr_pins_free, // Address pins usable as ports
    output logic irq_out, // Interrupt pin value
    output logic irq_oe_n, // Interrupt pin enable, low drives
    output logic not_initialized_flag, // Waiting for host configuration
    output logic shared_pin_out, // Shared scan pin value
    output logic shared_pin_oe_n // Shared scan pin enable, low drives
);
    // ****************************************
    // Synchronisers and reset sources
    // ****************************************
    logic [1:0] rp_s1_q, por_s1_q, slow_s2_q, addr_s2_q;
    logic [7:0] por_cnt_q;
    logic por_hold_q, pin_hold_q, cmd_hold_q;
    logic [$clog2(clock_reset_pkg::release_cycles+1)-1:0] rel_cnt_q;
    logic rst_any;

    always_ff @(posedge clock) begin
        rp_s1_q <= {rp_s1_q[0], reset_pin_n};
        por_s1_q <= {por_s1_q[0], por_active};
    end

    // Two flops each for slow pins and address pins
    logic [1:0] sl_a_q, sl_b_q, ad_a_q, ad_b_q;
    always_ff @(posedge clock) begin
        sl_a_q <= {crystal_input, slow_clock_input};
        sl_b_q <= sl_a_q;
        ad_a_q <= addr_pins;
        ad_b_q <= ad_a_q;
    end
    assign slow_s2_q = sl_b_q;
    assign addr_s2_q = ad_b_q;

    wire pin_low = !rp_s1_q[1];
    wire por_low = por_s1_q[1];

    // Power-on counter runs on the RC tick and releases on underflow
    always_ff @(posedge clock) begin
        if (por_low) begin
            por_cnt_q <= clock_reset_pkg::por_preset;
            por_hold_q <= 1'b1;
        end else if (!rstn) begin
            // Block reset starts with no power-on count pending
            por_cnt_q <= clock_reset_pkg::por_preset;
            por_hold_q <= 1'b0;
        end else if (por_hold_q && por_rc_tick) begin
            if (por_cnt_q == 8'h0000) begin
                por_hold_q <= 1'b0;
            end else begin
                por_cnt_q <= por_cnt_q - 8'h0001;
            end
        end
    end

    // Release delay after pin or command reset; stays well inside 1400 ns
    always_ff @(posedge clock) begin
        if (!rstn || pin_low || reset_command) begin
            rel_cnt_q <= '0;
            pin_hold_q <= 1'b1;
        end else if (pin_hold_q) begin
            if (rel_cnt_q == ($bits(rel_cnt_q))'(clock_reset_pkg::release_cycles / 2)) begin
                pin_hold_q <= 1'b0;
            end else begin
                rel_cnt_q <= rel_cnt_q + 1'b1;
            end
        end
    end
    assign rst_any = pin_hold_q || por_hold_q || pin_low || por_low;
    always_ff @(posedge clock) in_reset <= rst_any;

    // ****************************************
    // Configuration register
    // ****************************************
    clock_reset_pkg::clock_cfg_t cfg_q;
    always_ff @(posedge clock) begin
        if (rst_any) begin
            cfg_q <= {clock_reset_pkg::cfg_reset[clock_reset_pkg::buf_bit],
                clock_reset_pkg::cfg_reset[clock_reset_pkg::src_bit], clock_reset_pkg::cfg_reset[1:0]};
        end else if (cfg_write) begin
            cfg_q.buffer_enable <= cfg_data[clock_reset_pkg::buf_bit];
            cfg_q.source_select <= cfg_data[clock_reset_pkg::src_bit];
            cfg_q.timebase_select <= cfg_data[1:0];
        end
    end
    always_ff @(posedge clock) begin
        clock_configuration <= {1'b0, cfg_q.buffer_enable, 2'b00, cfg_q.source_select, 1'b0,
            cfg_q.timebase_select};
    end

    // ****************************************
    // Halt control and clock dividers
    // ****************************************
    clock_reset_pkg::power_state_t state_q;
    logic [idle_width-1:0] idle_q;
    wire wake = key_event || bus_start;
    always_ff @(posedge clock) begin
        if (rst_any) begin
            state_q <= clock_reset_pkg::st_reset;
            idle_q <= '0;
        end else begin
            case (state_q)
                clock_reset_pkg::st_reset: begin
                    state_q <= clock_reset_pkg::st_run;
                end
                clock_reset_pkg::st_run: begin
                    if (activity || wake) begin
                        idle_q <= '0;
                    end else if (idle_q >= idle_limit) begin
                        state_q <= clock_reset_pkg::st_halt;
                    end else begin
                        idle_q <= idle_q + 1'b1;
                    end
                end
                default: begin
                    idle_q <= '0;
                    if (wake) begin
                        state_q <= clock_reset_pkg::st_run;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clock) halted <= (state_q == clock_reset_pkg::st_halt);

    logic [5:0] pdiv_q, pwm_q;
    wire run = (state_q == clock_reset_pkg::st_run) && !rst_any;
    always_ff @(posedge clock) begin
        if (rst_any || !run) begin
            pdiv_q <= '0;
            proc_tick <= 1'b0;
        end else begin
            proc_tick <= (pdiv_q == 6'(clock_reset_pkg::proc_div - 1));
            pdiv_q <= (pdiv_q == 6'(clock_reset_pkg::proc_div - 1)) ? 6'h0000 : pdiv_q + 6'h0001;
        end
    end
    wire div_edge = run && (pdiv_q == 6'(clock_reset_pkg::proc_div - 1));
    always_ff @(posedge clock) begin
        if (rst_any) begin
            pwm_q <= '0;
        end else if (div_edge) begin
            pwm_q <= pwm_q + 6'h0001;
        end
    end

    // ****************************************
    // Timebase selection and shared pin
    // ****************************************
    wire slow_lvl = cfg_q.source_select ? slow_s2_q[0] : slow_s2_q[1];
    logic slow_prev_q;
    wire div_lvl = pwm_q[5];
    wire use_slow = (cfg_q.timebase_select == clock_reset_pkg::sel_slow);
    always_ff @(posedge clock) begin
        if (rst_any) begin
            // Track the pin so no false edge follows reset
            slow_prev_q <= slow_lvl;
            pwm_timebase <= 1'b0;
            pwm_tick <= 1'b0;
        end else begin
            slow_prev_q <= slow_lvl;
            pwm_timebase <= use_slow ? slow_lvl : div_lvl;
            pwm_tick <= use_slow ? (slow_lvl && !slow_prev_q) : (div_edge && pwm_q == 6'h003f);
        end
    end
    always_ff @(posedge clock) begin
        if (pin_low || rst_any) begin
            shared_pin_out <= 1'b0;
            shared_pin_oe_n <= 1'b1;
        end else if (cfg_q.buffer_enable) begin
            shared_pin_out <= use_slow ? slow_lvl : div_lvl;
            shared_pin_oe_n <= 1'b0;
        end else begin
            shared_pin_out <= scan_out_8;
            shared_pin_oe_n <= scan_out_8_oe_n;
        end
    end

    // ****************************************
    // Address sampling and initialization interrupt
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst_any) begin
            bus_address <= clock_reset_pkg::addr_base + {5'h0000, addr_s2_q};
            addr_pins_free <= 1'b0;
        end else begin
            addr_pins_free <= 1'b1;
        end
    end

    logic [$clog2(irq_set_cycles+1)-1:0] set_cnt_q;
    logic [$clog2(irq_clear_cycles+1)-1:0] clr_cnt_q;
    logic irq_q, push_pull_q, clr_pend_q;
    always_ff @(posedge clock) begin
        if (rst_any) begin
            set_cnt_q <= '0;
            clr_cnt_q <= '0;
            irq_q <= 1'b0;
            clr_pend_q <= 1'b0;
            not_initialized_flag <= 1'b1;
        end else begin
            if (!irq_q && not_initialized_flag && set_cnt_q != ($bits(set_cnt_q))'(irq_set_cycles)) begin
                set_cnt_q <= set_cnt_q + 1'b1;
            end
            if (set_cnt_q == ($bits(set_cnt_q))'(irq_set_cycles - 1) && not_initialized_flag) begin
                irq_q <= 1'b1;
            end
            if (init_command) begin
                clr_pend_q <= 1'b1;
                clr_cnt_q <= '0;
                not_initialized_flag <= 1'b0;
            end else if (clr_pend_q) begin
                if (clr_cnt_q == ($bits(clr_cnt_q))'(irq_clear_cycles - 1)) begin
                    irq_q <= 1'b0;
                    clr_pend_q <= 1'b0;
                end else begin
                    clr_cnt_q <= clr_cnt_q + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst_any) begin
            push_pull_q <= 1'b0;
        end else if (push_pull_set) begin
            push_pull_q <= 1'b1;
        end
    end
    // Active-low pin; open-drain only ever drives low
    always_ff @(posedge clock) begin
        if (pin_low || rst_any) begin
            irq_out <= 1'b0;
            irq_oe_n <= 1'b1;
        end else begin
            irq_out <= !irq_q;
            irq_oe_n <= push_pull_q ? 1'b0 : !irq_q;
        end
    end
endmodule

// File: design/clock_reset_pkg.sv
// Constants and carrier types for the clock and reset control block.
// Assumes a single 100 MHz clock standing in for the on-chip system clock.
package clock_reset_pkg;
    localparam int unsigned clock_mhz = 100;
    localparam int unsigned proc_clock_mhz = 2;
    localparam int unsigned proc_div = clock_mhz / proc_clock_mhz;
    localparam int unsigned pwm_div = 64;
    localparam int unsigned release_ns = 1400;
    localparam int unsigned release_cycles = release_ns * clock_mhz / 1000;
    localparam int unsigned irq_set_us = 100;
    localparam int unsigned irq_set_cycles = irq_set_us * clock_mhz;
    localparam int unsigned irq_clear_us = 90;
    localparam int unsigned irq_clear_cycles = irq_clear_us * clock_mhz;
    localparam logic [7:0] por_preset = 8'h00ff;
    localparam int unsigned buf_bit = 6;
    localparam int unsigned src_bit = 3;
    localparam logic [7:0] cfg_reset = 8'h0000;
    localparam logic [7:0] cfg_used_mask = 8'h004b;
    localparam logic [1:0] sel_divided = 2'h0;
    localparam logic [1:0] sel_slow = 2'h3;
    localparam logic [6:0] addr_base = 7'h0042;

    typedef struct packed {
        logic buffer_enable;
        logic source_select;
        logic [1:0] timebase_select;
    } clock_cfg_t;

    typedef enum logic [1:0] {
        st_reset = 2'b00,
        st_run = 2'b01,
        st_halt = 2'b10
    } power_state_t;
endpackage

// File: verif/clock_reset_chk.sv
// Assertion checker bound to the ports of clock_and_reset_control.
// Assumes one clock domain and the synchronous active-low rstn.
`timescale 1ns/1ps
module clock_reset_chk #(
    parameter int unsigned irq_set_cycles = 20
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Sync reset
    input wire logic reset_pin_n, // Reset pin
    input wire logic por_active, // Power-on reset
    input wire logic key_event, // Key event
    input wire logic bus_start, // Bus start
    input wire logic [7:0] clock_configuration, // Readback
    input wire logic proc_tick, // Processing tick
    input wire logic halted, // Halt state
    input wire logic in_reset, // Internal reset
    input wire logic addr_pins_free, // Address pins free
    input wire logic irq_oe_n, // Interrupt enable
    input wire logic shared_pin_oe_n // Shared pin enable
);
    localparam int irq_lim = irq_set_cycles + 4;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    chk_tick_spacing: assert property (proc_tick && !in_reset |-> ##50 (proc_tick || halted || in_reset))
        else $error("processing tick spacing wrong");
    chk_halt_no_tick: assert property (halted |-> !proc_tick)
        else $error("tick while halted");
    chk_wake_next: assert property (halted && (key_event || bus_start) |-> ##2 !halted)
        else $error("no wake after event");
    chk_buffer_pin: assert property (clock_configuration[6] && !in_reset |-> !shared_pin_oe_n)
        else $error("buffer enabled but pin not driven");
    chk_unused_bits: assert property ((clock_configuration & ~clock_reset_pkg::cfg_used_mask) == 8'h00)
        else $error("ignored bit reached readback");
    chk_reset_default: assert property (in_reset && $past(in_reset) |->
        clock_configuration == clock_reset_pkg::cfg_reset && !addr_pins_free)
        else $error("state not default in reset");
    chk_pin_reset: assert property (!reset_pin_n |-> ##[0:4] in_reset)
        else $error("pin reset not seen");
    chk_release_time: assert property ($rose(reset_pin_n) && !por_active |-> ##[1:140] !in_reset)
        else $error("reset release too slow");
    chk_irq_raise: assert property ($fell(in_reset) |-> ##[1:irq_lim] !irq_oe_n)
        else $error("interrupt not raised after reset");
endmodule

bind clock_and_reset_control clock_reset_chk #(.irq_set_cycles(irq_set_cycles)) clock_reset_chk_inst (
    .clock(clock),
    .rstn(rstn),
    .reset_pin_n(reset_pin_n),
    .por_active(por_active),
    .key_event(key_event),
    .bus_start(bus_start),
    .clock_configuration(clock_configuration),
    .proc_tick(proc_tick),
    .halted(halted),
    .in_reset(in_reset),
    .addr_pins_free(addr_pins_free),
    .irq_oe_n(irq_oe_n),
    .shared_pin_oe_n(shared_pin_oe_n)
);

// File: verif/host_model.sv
// Host processor model on the far side of the configuration interface.
// Assumes the bench calls its tasks; strobes change on falling edges.
`timescale 1ns/1ps
module host_model (
    input wire logic clock, // System clock
    output logic cfg_write, // Configuration write strobe
    output logic [7:0] cfg_data, // Configuration byte
    output logic init_command, // Host configuration command
    output logic bus_start // Bus start condition
);
    initial begin
        cfg_write = 1'b0;
        cfg_data = 8'h00;
        init_command = 1'b0;
        bus_start = 1'b0;
    end
    task automatic write_cfg(input logic [7:0] val);
        @(negedge clock);
        cfg_write = 1'b1;
        cfg_data = val & clock_reset_pkg::cfg_used_mask;
        @(negedge clock);
        cfg_write = 1'b0;
        cfg_data = ~cfg_data; // Stale byte inverted after release
    endtask
    task automatic strobe(input logic start);
        @(negedge clock);
        init_command = !start;
        bus_start = start;
        @(negedge clock);
        init_command = 1'b0;
        bus_start = 1'b0;
    endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for clock_and_reset_control with a host model.
// Assumes short interrupt delays; both slow clock pins toggle freely.
`timescale 1ns/1ps
module tb_top;
    logic clock, rstn, reset_pin_n, por_active, por_rc_tick, reset_command, push_pull_set;
    logic activity, key_event, bus_start, slow_clock_input, crystal_input, scan_out_8, scan_out_8_oe_n;
    logic cfg_write, init_command, proc_tick, pwm_tick, pwm_timebase, halted, in_reset, addr_pins_free;
    logic irq_out, irq_oe_n, not_initialized_flag, shared_pin_out, shared_pin_oe_n;
    logic [7:0] cfg_data, clock_configuration, v;
    logic [23:0] idle_limit;
    logic [6:0] bus_address;
    logic [1:0] addr_pins, wr_p;
    logic [7:0] exp_q[$];
    int fails, cmp_count, seed, cyc, n, hi;
    clock_and_reset_control #(.irq_set_cycles(20), .irq_clear_cycles(15)) clock_and_reset_control_inst (.*);
    host_model host_model_inst (.*);
    task automatic end_sim;
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return in_reset;
            1: return halted;
            2: return irq_oe_n;
            3: return pwm_tick;
            default: return irq_out;
        endcase
    endfunction
    task automatic wait_lvl(input int k, input logic lvl, input int lim);
        n = 0;
        while (pick(k) !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
        check(pick(k), lvl);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    // Timebase period between ticks, and its high time as a half period
    task automatic tick_period(input int exp);
        wait_lvl(3, 1'b1, 4000);
        n = 0;
        hi = 0;
        do begin
            @(negedge clock);
            n++;
            if (pwm_timebase === 1'b1) hi++;
        end while (pwm_tick !== 1'b1 && n < 4000);
        check(n, exp);
        check(hi, exp / 2);
    endtask
    task automatic cfg(input logic [7:0] val);
        exp_q.push_back(val & clock_reset_pkg::cfg_used_mask);
        host_model_inst.write_cfg(val);
    endtask
    // ****
    // Readback monitor and hang guard
    // ****
    always @(posedge clock) begin
        #1;
        if (wr_p[1]) begin
            check(clock_configuration, exp_q.pop_front());
        end
        wr_p = {wr_p[0], cfg_write & ~in_reset};
        cyc++;
        if (cyc == 40000) begin
            $display("ERROR %0t: timeout", $time);
            fails++;
            end_sim();
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Half periods of 17 and 23 clocks, off the sampling edge
    always #170 slow_clock_input = ~slow_clock_input;
    always #230 crystal_input = ~crystal_input;
    initial begin
        seed = 32'h5c7d;
        // Of the control bits only reset_pin_n, activity and scan_out_8_oe_n start high
        {rstn, reset_pin_n, por_active, por_rc_tick, reset_command, push_pull_set} = 6'h10;
        {activity, key_event, slow_clock_input, crystal_input, scan_out_8, scan_out_8_oe_n, wr_p} = 8'h84;
        idle_limit = 24'h00_0014;
        addr_pins = 2'($random(seed));
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        wait_lvl(0, 1'b0, 300);
        v = {6'h00, addr_pins};
        check(bus_address, clock_reset_pkg::addr_base + v);
        addr_pins = ~addr_pins;
        check(not_initialized_flag, 1'b1);
        wait_lvl(2, 1'b0, 25);
        check({addr_pins_free, bus_address}, {1'b1, clock_reset_pkg::addr_base + v[6:0]});
        scan_out_8_oe_n = 1'b0;
        scan_out_8 = 1'($random(seed));
        repeat (4) @(negedge clock);
        check({shared_pin_oe_n, shared_pin_out}, {1'b0, scan_out_8});
        tick_period(clock_reset_pkg::proc_div * clock_reset_pkg::pwm_div);
        cfg(8'h40 | (8'h08 & 8'($random(seed))));
        repeat (4) @(negedge clock);
        check(shared_pin_oe_n, 1'b0);
        host_model_inst.strobe(1'b0);
        wait_lvl(2, 1'b1, 20);
        check(not_initialized_flag, 1'b0);
        activity = 1'b0;
        wait_lvl(1, 1'b1, 60);
        repeat (60) @(negedge clock);
        pulse(key_event);
        wait_lvl(1, 1'b0, 2);
        wait_lvl(1, 1'b1, 60);
        repeat (60) @(negedge clock);
        host_model_inst.strobe(1'b1);
        wait_lvl(1, 1'b0, 2);
        activity = 1'b1;
        reset_pin_n = 1'b0;
        wait_lvl(0, 1'b1, 5);
        check({shared_pin_oe_n, irq_oe_n}, 2'b11);
        repeat (80) @(negedge clock);
        reset_pin_n = 1'b1;
        wait_lvl(0, 1'b0, 140);
        check(clock_configuration, clock_reset_pkg::cfg_reset);
        wait_lvl(2, 1'b0, 25);
        check(irq_out, 1'b0);
        v = 8'h03 | (8'h48 & 8'($random(seed)));
        cfg(v);
        repeat (4) @(negedge clock);
        tick_period(v[3] ? 34 : 46);
        pulse(reset_command);
        wait_lvl(0, 1'b1, 5);
        wait_lvl(0, 1'b0, 140);
        check(irq_oe_n, 1'b1);
        pulse(push_pull_set);
        @(negedge clock);
        check({irq_oe_n, irq_out}, 2'b01);
        wait_lvl(4, 1'b0, 25);
        por_active = 1'b1;
        wait_lvl(0, 1'b1, 5);
        repeat (5) @(negedge clock);
        por_active = 1'b0;
        // Ticks count only once the synchronised supply flag has dropped
        repeat (2) @(negedge clock);
        repeat (255) begin
            pulse(por_rc_tick);
            @(negedge clock);
        end
        check(in_reset, 1'b1);
        pulse(por_rc_tick);
        wait_lvl(0, 1'b0, 20);
        wait_lvl(2, 1'b0, 25);
        end_sim();
    end
endmodule
